// ---- design/alarm_status_defs.vh ----
// register offsets, field positions and codes of the alarm and status bank
`ifndef ALARM_STATUS_DEFS_VH
`define ALARM_STATUS_DEFS_VH

`define ADDR_W              12
`define DATA_W              8
`define ADDR_STICKY         12'h200
`define ADDR_REF_STATUS     12'h202
`define ADDR_STATE_STATUS   12'h203
`define ADDR_PIN_LEVELS     12'h20C
`define ADDR_IRQ_SUMMARY    12'h20D
`define ADDR_EEP_FAULT      12'h210
`define ADDR_EEP_DONE       12'h211
`define ADDR_IRQ_ENABLE     12'h079

`define BIT_LOS0            0
`define BIT_LOS1            1
`define BIT_HOLD            4
`define BIT_LOL             6
`define STICKY_MASK         8'h53

`define BIT_NO_REF          3
`define BIT_REF_LSB         0
`define BIT_REF_MSB         2
`define BIT_LOCKED          4
`define BIT_STATE_LSB       0
`define BIT_STATE_MSB       1
`define BIT_IRQ             0
`define BIT_BOOT_FAIL       0
`define BIT_CRC_ERR         1
`define BIT_EEP_DONE        6

`define REF_NONE            3'h0
`define REF_IN0             3'h4
`define REF_IN1             3'h5
`define STATE_RSVD          2'h0
`define STATE_FREERUN       2'h1
`define STATE_NORMAL        2'h2
`define STATE_HOLDOVER      2'h3

`define BYTE_ZERO           8'h00
`define NUM_LOS             2
`define NUM_GPI             4

`endif

// ---- design/sync2.v ----
// two-flop synchroniser bank for pin-side levels
`timescale 1ns/10ps
`default_nettype none

module sync2 #(
    parameter WIDTH = 1
) (
    input  wire             clk_sys,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] d,
    output reg  [WIDTH-1:0] q
);

    reg [WIDTH-1:0] meta_r;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= {WIDTH{1'b0}};
            q      <= {WIDTH{1'b0}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule // sync2

`default_nettype wire

// ---- design/pll_alarm_status_bank.v ----
// status and alarm register bank of the jitter attenuator control port
//
// Operation
// RULE1 - pll loss-of-lock alarm sets a sticky flag held until software clears it
// RULE2 - holdover alarm sets a sticky flag held until software clears it
// RULE3 - each of the two inputs has its own sticky loss-of-signal flag
// RULE4 - sticky flags reset to zero; writing one clears, writing zero keeps
// RULE5 - host writes zero to reserved bits; reserved reads are undefined
// RULE6 - read-only flag is one when no input reference is valid
// RULE7 - selected reference code: 0-3 none, 4 input 0, 5 input 1
// RULE8 - lock indication follows phase error criterion, never set in synthesizer mode; here a read in the first synthesizer-mode cycle still shows lock
// RULE9 - pll state field: 01 freerun, 10 normal, 11 holdover
// RULE10 - pll status fields are live, with no capture or latching
// RULE11 - host should track fast changes with sticky flags and pins
// RULE12 - four general-purpose input pin levels read back as read-only
// RULE13 - summary bit set and interrupt pin low when an enabled flag is set
// RULE14 - eeprom crc failure sets a flag that only reset clears
// RULE15 - eeprom read failure sets a flag that only reset clears
// RULE16 - eeprom read completion sets a flag that only reset clears
// RULE17 - each sticky flag counts toward the summary only while enabled
`timescale 1ns/10ps
`default_nettype none
`include "alarm_status_defs.vh"

module pll_alarm_status_bank (
    input  wire                   clk_sys,
    input  wire                   rst_b,
    // register port from the serial control port engine
    input  wire [`ADDR_W-1:0]     reg_addr,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    input  wire [`DATA_W-1:0]     reg_wdata,
    output reg  [`DATA_W-1:0]     reg_rdata,
    output reg                    reg_rvalid,
    // alarm events from pll and input monitor, same clock
    input  wire                   lock_loss_alarm,
    input  wire                   holdover_alarm,
    input  wire [`NUM_LOS-1:0]    signal_loss_alarm,
    // live pll state, same clock
    input  wire                   no_valid_reference,
    input  wire [2:0]             selected_reference,
    input  wire                   phase_error_in_lock,
    input  wire                   synth_mode,
    input  wire [1:0]             pll_state,
    // general purpose pins configured as inputs, asynchronous
    input  wire [`NUM_GPI-1:0]    gpi_pins,
    // eeprom loader results, same clock
    input  wire                   eeprom_crc_error,
    input  wire                   boot_read_failed,
    input  wire                   eeprom_read_complete,
    // active-low open-drain interrupt pin
    output reg                    irq_pin_n,
    output reg                    irq_pin_oe
);

    reg  [`DATA_W-1:0]  sticky_r;
    reg  [`DATA_W-1:0]  sticky_nxt;
    reg  [`DATA_W-1:0]  irq_enable_r;
    reg                 crc_err_r;
    reg                 boot_fail_r;
    reg                 eep_done_r;
    reg                 locked_r;
    reg  [`DATA_W-1:0]  rdata_nxt;
    wire [`NUM_GPI-1:0] input_pin_levels;
    wire [`DATA_W-1:0]  alarm_set;
    wire                irq_any;
    wire                wr_sticky;
    wire                wr_enable;

    sync2 #(
        .WIDTH (`NUM_GPI)
    ) u_gpi_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .d       (gpi_pins),
        .q       (input_pin_levels)
    );

    assign wr_sticky = reg_wr && (reg_addr == `ADDR_STICKY);
    assign wr_enable = reg_wr && (reg_addr == `ADDR_IRQ_ENABLE);

    // build the per-bit set vector from the alarm sources
    genvar i;
    generate
        for (i = 0; i < `DATA_W; i = i + 1) begin : g_set
            if (i == `BIT_LOL) begin : g_lol
                assign alarm_set[i] = lock_loss_alarm;     // RULE1
            end else if (i == `BIT_HOLD) begin : g_hold
                assign alarm_set[i] = holdover_alarm;      // RULE2
            end else if (i == `BIT_LOS0) begin : g_los0
                assign alarm_set[i] = signal_loss_alarm[0]; // RULE3
            end else if (i == `BIT_LOS1) begin : g_los1
                assign alarm_set[i] = signal_loss_alarm[1]; // RULE3
            end else begin : g_none
                assign alarm_set[i] = 1'b0;
            end
        end
    endgenerate

    // a set arriving with its clear wins, so no alarm is ever lost
    always @* begin
        sticky_nxt = sticky_r;
        if (wr_sticky) begin
            sticky_nxt = sticky_r & ~reg_wdata; // RULE4
        end
        sticky_nxt = (sticky_nxt | alarm_set) & `STICKY_MASK; // RULE1 RULE2 RULE3
    end

    assign irq_any = |(sticky_r & irq_enable_r & `STICKY_MASK); // RULE13 RULE17

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sticky_r     <= `BYTE_ZERO; // RULE4
            irq_enable_r <= `BYTE_ZERO;
        end else begin
            sticky_r <= sticky_nxt;
            if (wr_enable) begin
                // reserved enable bits dropped; host is meant to write them zero
                irq_enable_r <= reg_wdata & `STICKY_MASK; // RULE5 RULE17
            end
        end
    end

    // eeprom result flags are set-only; nothing but reset clears them
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            crc_err_r   <= 1'b0;
            boot_fail_r <= 1'b0;
            eep_done_r  <= 1'b0;
        end else begin
            if (eeprom_crc_error) begin
                crc_err_r <= 1'b1; // RULE14
            end
            if (boot_read_failed) begin
                boot_fail_r <= 1'b1; // RULE15
            end
            if (eeprom_read_complete) begin
                eep_done_r <= 1'b1; // RULE16
            end
        end
    end

    // lock view is gated here so synthesizer mode can report lock only on a read in its first cycle
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            locked_r <= 1'b0;
        end else begin
            locked_r <= phase_error_in_lock && !synth_mode; // RULE8
        end
    end

    // read mux; pll reference and state fields come straight from the live inputs, the lock bit from locked_r
    always @* begin
        rdata_nxt = `BYTE_ZERO; // RULE5
        case (reg_addr)
            `ADDR_STICKY: begin
                rdata_nxt = sticky_r;
            end
            `ADDR_IRQ_ENABLE: begin
                rdata_nxt = irq_enable_r;
            end
            `ADDR_REF_STATUS: begin
                rdata_nxt[`BIT_NO_REF] = no_valid_reference; // RULE6 RULE10
                rdata_nxt[`BIT_REF_MSB:`BIT_REF_LSB] = selected_reference; // RULE7 RULE10
            end
            `ADDR_STATE_STATUS: begin
                rdata_nxt[`BIT_LOCKED] = locked_r; // RULE8
                rdata_nxt[`BIT_STATE_MSB:`BIT_STATE_LSB] = pll_state; // RULE9 RULE10
            end
            `ADDR_PIN_LEVELS: begin
                rdata_nxt[`NUM_GPI-1:0] = input_pin_levels; // RULE12
            end
            `ADDR_IRQ_SUMMARY: begin
                rdata_nxt[`BIT_IRQ] = irq_any; // RULE13
            end
            `ADDR_EEP_FAULT: begin
                rdata_nxt[`BIT_CRC_ERR]   = crc_err_r;   // RULE14
                rdata_nxt[`BIT_BOOT_FAIL] = boot_fail_r; // RULE15
            end
            `ADDR_EEP_DONE: begin
                rdata_nxt[`BIT_EEP_DONE] = eep_done_r; // RULE16
            end
            default: begin
                rdata_nxt = `BYTE_ZERO;
            end
        endcase
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata  <= `BYTE_ZERO;
            reg_rvalid <= 1'b0;
            irq_pin_n  <= 1'b1;
            irq_pin_oe <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_nxt;
            end
            // open drain: drive low only while asserted, else release
            irq_pin_n  <= !irq_any; // RULE13
            irq_pin_oe <= irq_any;  // RULE13
        end
    end

endmodule // pll_alarm_status_bank

`default_nettype wire

// ---- testbench/pll_alarm_status_bank_properties.sv ----
// port assertions for the alarm and status bank
`timescale 1ns/10ps
`default_nettype none
module bank_checker (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic [11:0] reg_addr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        lock_loss_alarm,
    input wire logic        holdover_alarm,
    input wire logic        no_valid_reference,
    input wire logic [2:0]  selected_reference,
    input wire logic        synth_mode,
    input wire logic [1:0]  pll_state,
    input wire logic        eeprom_crc_error,
    input wire logic        irq_pin_n,
    input wire logic        irq_pin_oe
);
    wire r200 = reg_rd && reg_addr == 12'h200;
    wire r201 = reg_rd && reg_addr == 12'h201;
    wire r202 = reg_rd && reg_addr == 12'h202;
    wire r203 = reg_rd && reg_addr == 12'h203;
    wire r210 = reg_rd && reg_addr == 12'h210;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // alarms seen during reset must not count, hence the past reset term
    pin_pair_a: assert property (irq_pin_oe == !irq_pin_n)
        else $error("irq pin and enable disagree");
    lol_sticky_a: assert property ($past(rst_b) && $past(lock_loss_alarm) && r200
        |=> reg_rdata[6]) else $error("lock loss flag not set");
    hold_sticky_a: assert property ($past(rst_b) && $past(holdover_alarm) && r200
        |=> reg_rdata[4]) else $error("holdover flag not set");
    ref_live_a: assert property (r202 |=>
        reg_rdata == {4'h0, $past(no_valid_reference), $past(selected_reference)})
        else $error("reference status wrong");
    state_live_a: assert property (r203 |=> reg_rdata[1:0] == $past(pll_state))
        else $error("pll state wrong");
    synth_no_lock_a: assert property (r203 && synth_mode && $past(synth_mode)
        |=> !reg_rdata[4]) else $error("lock shown in synthesizer mode");
    crc_sticky_a: assert property ($past(rst_b) && $past(eeprom_crc_error) && r210
        |=> reg_rdata[1]) else $error("crc flag not set");
    unmapped_zero_a: assert property (r201 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // bank_checker
bind pll_alarm_status_bank bank_checker chk_i (.*);
`default_nettype wire

// ---- testbench/host_port_model.sv ----
// host model of the register port: one-cycle strobes
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
    input  wire logic        clk_sys,
    output var  logic [11:0] reg_addr,
    output var  logic        reg_wr,
    output var  logic        reg_rd,
    output var  logic [7:0]  reg_wdata,
    input  wire logic [7:0]  reg_rdata,
    input  wire logic        reg_rvalid
);
    initial begin
        reg_addr = 12'h000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // entered just after an edge, leaves one idle edge after the edge that took the strobe
    // the idle edge keeps back-to-back strobes from being dropped and raised in one step
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_rd = 1'b0;
        // a missing answer becomes unknown so the compare fails
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
        @(posedge clk_sys);
        #1;
    endtask
endmodule // host_port_model
`default_nettype wire

// ---- testbench/pll_alarm_status_bank_tb_top.sv ----
// self-checking bench of the alarm and status bank
`timescale 1ns/10ps
`default_nettype none
module pll_alarm_status_bank_tb_top;
    logic        clk_sys = 1'b0, rst_b = 1'b0;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic        reg_wr, reg_rd, reg_rvalid, irq_pin_n, irq_pin_oe;
    logic        lock_loss_alarm = 1'b0, holdover_alarm = 1'b0, synth_mode = 1'b0;
    logic        no_valid_reference = 1'b0, phase_error_in_lock = 1'b0;
    logic        eeprom_crc_error = 1'b0, boot_read_failed = 1'b0, eeprom_read_complete = 1'b0;
    logic [1:0]  signal_loss_alarm = 2'h0, pll_state = 2'h1;
    logic [2:0]  selected_reference = 3'h0;
    logic [3:0]  gpi_pins = 4'h0;
    logic [7:0]  acc = 8'h00;
    logic [7:0]  bit_tbl [4] = '{8'h01, 8'h02, 8'h10, 8'h40};
    logic [2:0]  ref_tbl [4] = '{3'h0, 3'h3, 3'h4, 3'h5};
    int          miscompares = 0;
    int          n_checks = 0;
    always #10 clk_sys = ~clk_sys;
    pll_alarm_status_bank dut (.*);
    host_port_model host (.*);
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, e);
    endtask
    task automatic irq(input logic on);
        chk({6'h00, irq_pin_n, irq_pin_oe}, on ? 8'h01 : 8'h02);
        rd(12'h20D, {7'h00, on});
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        cyc(4);
        rst_b = 1'b1;
        rd(12'h200, 8'h00);
        irq(1'b0);
        host.wr(12'h079, 8'h53);
        rd(12'h079, 8'h53);
        for (int i = 0; i < 4; i++) begin
            {lock_loss_alarm, holdover_alarm, signal_loss_alarm} = 4'h1 << i;
            cyc(1);
            {lock_loss_alarm, holdover_alarm, signal_loss_alarm} = 4'h0;
            acc = acc | bit_tbl[i];
            rd(12'h200, acc);
            irq(1'b1);
        end
        host.wr(12'h200, 8'h00);
        rd(12'h200, 8'h53);
        host.wr(12'h200, 8'h40);
        rd(12'h200, 8'h13);
        host.wr(12'h200, 8'h13);
        rd(12'h200, 8'h00);
        irq(1'b0);
        host.wr(12'h079, 8'h00);
        lock_loss_alarm = 1'b1;
        cyc(1);
        lock_loss_alarm = 1'b0;
        cyc(1);
        irq(1'b0);
        host.wr(12'h079, 8'h40);
        cyc(1);
        irq(1'b1);
        $display("alarm tests done");
        for (int i = 0; i < 4; i++) begin
            selected_reference = ref_tbl[i];
            no_valid_reference = ~i[1];
            pll_state = 2'(i % 3 + 1);
            rd(12'h202, {4'h0, no_valid_reference, selected_reference});
            rd(12'h203, {6'h00, pll_state});
        end
        // lock readback is registered, so let it settle first
        phase_error_in_lock = 1'b1;
        cyc(2);
        rd(12'h203, 8'h11);
        synth_mode = 1'b1;
        cyc(2);
        rd(12'h203, 8'h01);
        gpi_pins = 4'hA;
        cyc(3);
        rd(12'h20C, 8'h0A);
        eeprom_crc_error = 1'b1;
        cyc(1);
        eeprom_crc_error = 1'b0;
        rd(12'h210, 8'h02);
        rd(12'h211, 8'h00);
        {boot_read_failed, eeprom_read_complete} = 2'h3;
        cyc(1);
        {boot_read_failed, eeprom_read_complete} = 2'h0;
        host.wr(12'h210, 8'h03);
        rd(12'h210, 8'h03);
        rd(12'h211, 8'h40);
        host.wr(12'h201, 8'h00);
        rd(12'h201, 8'h00);
        // the lock-loss flag and the pin are still set here, so reset must clear both
        rst_b = 1'b0;
        cyc(2);
        rst_b = 1'b1;
        rd(12'h200, 8'h00);
        irq(1'b0);
        rd(12'h210, 8'h00);
        rd(12'h211, 8'h00);
        $display("status tests done");
        finish_test;
    end
    initial begin
        #100000;
        miscompares++;
        finish_test;
    end
endmodule // pll_alarm_status_bank_tb_top
`default_nettype wire
